// ==== logic/pbr_status_out.sv ====
// Status output, power-good output and push-button reset monitor with Avalon registers.
//
// What this block does
// - Drive the status line low while the battery is charging.
// - Release the status line when charge is done, disabled or in high impedance.
// - Send one 128 us pulse on the status line for each fault.
// - Charge indication on the status line only while its enable bit is set.
// - Pull power good low while supply is above battery-plus-sleep and below overvoltage.
// - In level shift mode power good follows the push-button level instead.
// - Assert reset output after the button is held low past the hold time.
// - Release the reset output after the 400 ms release delay.
// - Shorter presses raise two programmable wake interrupts at their thresholds.
// - A button press takes the device out of ship mode.
// - Four temperature faults are readable over the registers during charging.
// - Termination code gives 5 to 20 percent, and pre-charge equals it.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pbr_consts.svh"

module pbr_status_out #(
   parameter int US_CYCLES  = `PBR_US_NS / `PBR_CLK_PERIOD_NS,
   parameter int MS_US      = `PBR_MS_US,
   parameter int PULSE_US   = `PBR_FAULT_PULSE_US,
   parameter int RELEASE_MS = `PBR_RELEASE_MS
) (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire pbr_pkg::pbr_avl_req_t avlReq,
   output logic                       avlWaitrequest,
   output logic [31:0]                avlReaddata,
   input  wire pbr_pkg::pbr_chg_t     chargerState,
   input  wire logic                  faultIn,
   input  wire logic                  vinAboveBatSleep,
   input  wire logic                  vinOverVoltage,
   input  wire logic [3:0]            tempFaultIn,
   input  wire logic                  pushButtonN,
   output logic                       statusAlertOut,
   output logic                       statusAlertOe,
   output logic                       powerGoodOut,
   output logic                       powerGoodOe,
   output logic                       resetOutN,
   output logic                       resetOutOe,
   output logic                       shipMode,
   output logic [4:0]                 termPercent,
   output logic [4:0]                 prechargePercent,
   output logic                       irq
);
   import pbr_pkg::*;

   // Hold time chosen by the two-bit reset time field.
   function automatic logic [15:0] holdMs(input logic [1:0] sel);
      unique case (sel)
         2'h0: holdMs = `PBR_HOLD_MS0;
         2'h1: holdMs = `PBR_HOLD_MS1;
         2'h2: holdMs = `PBR_HOLD_MS2;
         2'h3: holdMs = `PBR_HOLD_MS3;
      endcase
   endfunction

   // Byte-lane merge of a write into a stored word.
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         laneMerge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   // Reset release through two flip-flops.
   logic rstMeta_reg;
   logic rstSync_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   wire logic rstN = rstSync_reg;

   localparam logic [15:0] PULSE_LOAD = 16'(PULSE_US + 1);
   localparam logic [15:0] REL_LAST   = 16'(RELEASE_MS - 1);

   // Register state.
   logic                    waitReq_reg, waitReq_next;
   logic [31:0]             rdata_reg, rdata_next;
   logic [7:0]              ctrl_reg, ctrl_next;
   logic [31:0]             wake_reg, wake_next;
   logic [`PBR_ST_W-1:0]    status_reg, status_next;
   logic [`PBR_ST_W-1:0]    mask_reg, mask_next;
   logic [3:0]              term_reg, term_next;
   logic                    irq_reg, irq_next;

   // Timing and button state.
   logic [15:0]             usCnt_reg, usCnt_next;
   logic [15:0]             msCnt_reg, msCnt_next;
   logic [15:0]             pulseCnt_reg, pulseCnt_next;
   logic [15:0]             pressMs_reg, pressMs_next;
   logic                    faultPrev_reg, faultPrev_next;
   pbr_btn_state_t          btn_reg, btn_next;
   logic                    alertOe_reg, alertOe_next;
   logic                    pgOe_reg, pgOe_next;
   logic                    rstOe_reg, rstOe_next;
   logic                    ship_reg;

   // Events raised by the timing group for the status register.
   logic [`PBR_ST_W-1:0]    evSet;
   logic                    shipExit;
   logic                    usTick;
   logic                    msTick;

   wire logic accept = (avlReq.read | avlReq.write) & ~waitReq_reg;
   wire logic [4:0] termPct = `PBR_TERM_BASE_PCT + {1'b0, term_reg};

   // Bus slave and registers: every access answers on the second edge.
   always_comb begin
      logic [31:0] rd;
      rd           = 32'h0;
      waitReq_next = 1'b1;
      rdata_next   = rdata_reg;
      ctrl_next    = ctrl_reg;
      wake_next    = wake_reg;
      mask_next    = mask_reg;
      term_next    = term_reg;
      status_next  = status_reg;
      unique case (avlReq.address)
         `PBR_OFF_CTRL:   rd = {24'h0, ctrl_reg};
         `PBR_OFF_WAKE:   rd = wake_reg;
         `PBR_OFF_STATUS: rd = {27'h0, status_reg};
         `PBR_OFF_MASK:   rd = {27'h0, mask_reg};
         `PBR_OFF_STATE:  rd = {24'h0,
                                 chargerState.charging ? tempFaultIn : 4'h0,
                                 rstOe_reg, ~pushButtonN, ~pgOe_reg, chargerState.charging};
         `PBR_OFF_TERM:   rd = {19'h0, termPct, 4'h0, term_reg};
         default:         rd = 32'h0;
      endcase
      // The first cycle of a request captures read data and drops waitrequest.
      if ((avlReq.read | avlReq.write) & waitReq_reg) begin
         waitReq_next = 1'b0;
         rdata_next   = avlReq.read ? rd : 32'h0;
      end
      if (accept & avlReq.write) begin
         unique case (avlReq.address)
            `PBR_OFF_CTRL: ctrl_next = 8'(laneMerge({24'h0, ctrl_reg}, avlReq.writedata,
                                                    avlReq.byteenable));
            `PBR_OFF_WAKE: wake_next = laneMerge(wake_reg, avlReq.writedata, avlReq.byteenable);
            `PBR_OFF_MASK: begin
               if (avlReq.byteenable[0]) begin
                  mask_next = avlReq.writedata[`PBR_ST_W-1:0];
               end
            end
            `PBR_OFF_TERM: begin
               if (avlReq.byteenable[0]) begin
                  term_next = avlReq.writedata[3:0];
               end
            end
            default: ;
         endcase
      end
      // A status read clears only the bits it returned, so no later event is lost.
      if (accept & avlReq.read & (avlReq.address == `PBR_OFF_STATUS)) begin
         status_next = status_reg & ~rdata_reg[`PBR_ST_W-1:0];
      end
      status_next = status_next | evSet;
      // Software enters ship mode through the control bit; a press clears it.
      if (shipExit) begin
         ctrl_next[`PBR_CTRL_SHIP] = 1'b0;
      end
      irq_next = |(status_reg & mask_reg);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         waitReq_reg <= 1'b1;
         rdata_reg   <= 32'h0;
         ctrl_reg    <= `PBR_CTRL_RESET;
         wake_reg    <= {`PBR_WAKE2_RESET, `PBR_WAKE1_RESET};
         status_reg  <= '0;
         mask_reg    <= '0;
         term_reg    <= 4'h0;
         irq_reg     <= 1'b0;
      end else begin
         waitReq_reg <= waitReq_next;
         rdata_reg   <= rdata_next;
         ctrl_reg    <= ctrl_next;
         wake_reg    <= wake_next;
         status_reg  <= status_next;
         mask_reg    <= mask_next;
         term_reg    <= term_next;
         irq_reg     <= irq_next;
      end
   end

   // Time base, fault pulse, pin drivers and button monitor.
   always_comb begin
      logic chargeInd;
      logic pressed;
      chargeInd = 1'b0;
      pressed   = ~pushButtonN;
      evSet     = '0;
      shipExit  = 1'b0;
      // One microsecond tick and one millisecond tick from the same counter chain.
      usTick     = (usCnt_reg == 16'(US_CYCLES - 1));
      usCnt_next = usTick ? 16'h0 : usCnt_reg + 16'h1;
      msTick     = usTick & (msCnt_reg == 16'(MS_US - 1));
      msCnt_next = msTick ? 16'h0 : (usTick ? msCnt_reg + 16'h1 : msCnt_reg);
      // A rising fault restarts the pulse; the extra tick keeps it at least the full width.
      faultPrev_next = faultIn;
      pulseCnt_next  = pulseCnt_reg;
      if (faultIn & ~faultPrev_reg) begin
         pulseCnt_next          = PULSE_LOAD;
         evSet[`PBR_ST_FAULT]   = 1'b1;
      end else if (usTick & (pulseCnt_reg != 16'h0)) begin
         pulseCnt_next = pulseCnt_reg - 16'h1;
      end
      // Charge indication, masked by the enable bit and the idle conditions.
      chargeInd = ctrl_reg[`PBR_CTRL_IND_EN] & chargerState.charging & ~chargerState.done
                  & ~chargerState.disabled & ~chargerState.hiZ;
      // The fault pulse flips the line so it shows even while charging holds it low.
      alertOe_next = chargeInd ^ (pulseCnt_reg != 16'h0);
      pgOe_next = ctrl_reg[`PBR_CTRL_SHIFT] ? pressed
                                            : (vinAboveBatSleep & ~vinOverVoltage);
      btn_next     = btn_reg;
      pressMs_next = pressMs_reg;
      rstOe_next   = rstOe_reg;
      unique case (btn_reg)
         PBR_IDLE: begin
            pressMs_next = 16'h0;
            if (pressed) begin
               btn_next = PBR_PRESS;
               if (ctrl_reg[`PBR_CTRL_SHIP]) begin
                  shipExit            = 1'b1;
                  evSet[`PBR_ST_SHIP] = 1'b1;
               end
            end
         end
         PBR_PRESS: begin
            if (!pressed) begin
               btn_next = PBR_IDLE;
            end else if (msTick) begin
               pressMs_next = pressMs_reg + 16'h1;
               if (pressMs_next == wake_reg[`PBR_WAKE1_LSB +: 16]) begin
                  evSet[`PBR_ST_WAKE1] = 1'b1;
               end
               if (pressMs_next == wake_reg[`PBR_WAKE2_LSB +: 16]) begin
                  evSet[`PBR_ST_WAKE2] = 1'b1;
               end
               // Held past the hold time: pull reset low.
               if (pressMs_reg >= holdMs(ctrl_reg[`PBR_CTRL_HOLD_LSB +: 2])) begin
                  btn_next             = PBR_RESET;
                  rstOe_next           = 1'b1;
                  pressMs_next         = 16'h0;
                  evSet[`PBR_ST_RESET] = 1'b1;
               end
            end
         end
         PBR_RESET: begin
            if (msTick) begin
               pressMs_next = pressMs_reg + 16'h1;
               if (pressMs_reg == REL_LAST) begin
                  btn_next   = PBR_RELEASE;
                  rstOe_next = 1'b0;
               end
            end
         end
         PBR_RELEASE: begin
            // Wait for the button to come up so one hold gives one reset.
            pressMs_next = 16'h0;
            if (!pressed) begin
               btn_next = PBR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         usCnt_reg     <= 16'h0;
         msCnt_reg     <= 16'h0;
         pulseCnt_reg  <= 16'h0;
         pressMs_reg   <= 16'h0;
         faultPrev_reg <= 1'b0;
         btn_reg       <= PBR_IDLE;
         alertOe_reg   <= 1'b0;
         pgOe_reg      <= 1'b0;
         rstOe_reg     <= 1'b0;
         ship_reg      <= 1'b0;
         termPercent   <= `PBR_TERM_BASE_PCT;
         prechargePercent <= `PBR_TERM_BASE_PCT;
      end else begin
         usCnt_reg     <= usCnt_next;
         msCnt_reg     <= msCnt_next;
         pulseCnt_reg  <= pulseCnt_next;
         pressMs_reg   <= pressMs_next;
         faultPrev_reg <= faultPrev_next;
         btn_reg       <= btn_next;
         alertOe_reg   <= alertOe_next;
         pgOe_reg      <= pgOe_next;
         rstOe_reg     <= rstOe_next;
         ship_reg      <= ctrl_next[`PBR_CTRL_SHIP];
         termPercent   <= termPct;
         prechargePercent <= termPct;
      end
   end

   // Open-drain pins only ever drive low, so their data is a constant low.
   assign statusAlertOut = 1'b0;
   assign powerGoodOut   = 1'b0;
   assign resetOutN      = 1'b0;
   assign statusAlertOe  = alertOe_reg;
   assign powerGoodOe    = pgOe_reg;
   assign resetOutOe     = rstOe_reg;
   assign shipMode       = ship_reg;
   assign avlWaitrequest = waitReq_reg;
   assign avlReaddata    = rdata_reg;
   assign irq            = irq_reg;

endmodule // pbr_status_out

// ==== logic/pbr_consts.svh ====
// Offsets, field positions, reset values and timing figures of the push-button status block.
`ifndef PBR_CONSTS_SVH
`define PBR_CONSTS_SVH

// Clock and time base.
`define PBR_CLK_PERIOD_NS   10
`define PBR_US_NS           1000
`define PBR_MS_US           1000
`define PBR_FAULT_PULSE_US  128
`define PBR_RELEASE_MS      400

// Register byte offsets.
`define PBR_ADDR_W          5
`define PBR_OFF_CTRL        5'h00
`define PBR_OFF_WAKE        5'h04
`define PBR_OFF_STATUS      5'h08
`define PBR_OFF_MASK        5'h0c
`define PBR_OFF_STATE       5'h10
`define PBR_OFF_TERM        5'h14

// Control register fields.
`define PBR_CTRL_IND_EN     0
`define PBR_CTRL_SHIFT      1
`define PBR_CTRL_SHIP       2
`define PBR_CTRL_HOLD_LSB   4
`define PBR_CTRL_RESET      8'h01

// Wake register fields, thresholds in milliseconds.
`define PBR_WAKE1_LSB       0
`define PBR_WAKE2_LSB       16
`define PBR_WAKE1_RESET     16'h0064
`define PBR_WAKE2_RESET     16'h03e8

// Status and mask bit positions.
`define PBR_ST_FAULT        0
`define PBR_ST_WAKE1        1
`define PBR_ST_WAKE2        2
`define PBR_ST_RESET        3
`define PBR_ST_SHIP         4
`define PBR_ST_W            5

// Reset hold time choices in milliseconds.
`define PBR_HOLD_MS0        16'h1388
`define PBR_HOLD_MS1        16'h2328
`define PBR_HOLD_MS2        16'h2af8
`define PBR_HOLD_MS3        16'h3a98

// Termination setting: percent of charge current is base plus code.
`define PBR_TERM_BASE_PCT   5'h05
`define PBR_TERM_MAX_CODE   4'hf

`endif

// ==== logic/pbr_pkg.sv ====
// Types shared by the push-button status block.
package pbr_pkg;

   // Button monitor states, Gray coded along idle, press, reset, release.
   typedef enum logic [1:0] {
      PBR_IDLE    = 2'b00,
      PBR_PRESS   = 2'b01,
      PBR_RESET   = 2'b11,
      PBR_RELEASE = 2'b10
   } pbr_btn_state_t;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } pbr_avl_req_t;

   // Charger state seen by the status logic.
   typedef struct packed {
      logic charging;
      logic done;
      logic disabled;
      logic hiZ;
   } pbr_chg_t;

endpackage

// ==== dv/pbr_far_end.sv ====
// Host board model: pull-ups on the open-drain lines and a push-button.
`timescale 1ns/1ps
module pbr_far_end (
   input  wire logic        clk,
   input  wire logic        statusAlertOe,
   input  wire logic        powerGoodOe,
   input  wire logic        resetOutOe,
   input  wire logic        pressGo,
   input  wire logic [31:0] pressLen,
   output logic             pushButtonN,
   output logic             statusLine,
   output logic             powerGoodLine,
   output logic             resetLineN
);
   logic [31:0] left;

   // Every line has a pull-up, so a released line reads high, never a stale value.
   assign statusLine    = !statusAlertOe;
   assign powerGoodLine = !powerGoodOe;
   assign resetLineN    = !resetOutOe;

   // The button stays low for the asked number of cycles, then springs back.
   initial begin
      pushButtonN = 1'b1;
      left        = 32'h0;
   end
   always @(posedge clk) begin
      if (pressGo) begin
         left        <= pressLen;
         pushButtonN <= 1'b0;
      end else if (left > 32'h1) begin
         left <= left - 32'h1;
      end else begin
         left        <= 32'h0;
         pushButtonN <= 1'b1;
      end
   end
endmodule // pbr_far_end

// ==== dv/pbr_status_out_monitor.sv ====
// Port checker for the push-button status block, bound into its top module.
`timescale 1ns/1ps
`include "pbr_consts.svh"
module pbr_status_out_monitor #(
   parameter int US_CYCLES  = 100,
   parameter int MS_US      = 1000,
   parameter int PULSE_US   = 128,
   parameter int RELEASE_MS = 400
) (
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire pbr_pkg::pbr_avl_req_t avlReq,
   input wire logic                  avlWaitrequest,
   input wire logic [31:0]           avlReaddata,
   input wire pbr_pkg::pbr_chg_t     chargerState,
   input wire logic                  faultIn,
   input wire logic                  vinAboveBatSleep,
   input wire logic                  vinOverVoltage,
   input wire logic                  pushButtonN,
   input wire logic                  statusAlertOe,
   input wire logic                  powerGoodOe,
   input wire logic                  resetOutOe,
   input wire logic                  shipMode,
   input wire logic [4:0]            termPercent,
   input wire logic [4:0]            prechargePercent
);
   import pbr_pkg::*;
   localparam int MSC  = MS_US * US_CYCLES;
   localparam int PLO  = PULSE_US * US_CYCLES;
   localparam int PHI  = (PULSE_US + 1) * US_CYCLES + 4;
   localparam int HOLD = `PBR_HOLD_MS0 * MSC;
   localparam int REL  = RELEASE_MS * MSC;
   logic [2:0]  upReg, upNext;
   logic [15:0] ageReg, ageNext;
   logic [31:0] pressReg, pressNext, lowReg, lowNext;
   logic        faultQ, shiftReg, shiftNext, indReg, indNext, ctrlWr, termWr, up, chgLvl, pgExp;

   // Bus snooping copies the control bits; hold checks assume hold select 0.
   always_comb begin
      ctrlWr    = avlReq.write && !avlWaitrequest && avlReq.address == `PBR_OFF_CTRL
                  && avlReq.byteenable[0];
      termWr    = avlReq.write && !avlWaitrequest && avlReq.address == `PBR_OFF_TERM
                  && avlReq.byteenable[0];
      up        = upReg == 3'h4;
      upNext    = up ? upReg : upReg + 3'h1;
      ageNext   = (faultIn && !faultQ) ? 16'h0 : ageReg + {15'h0, ageReg != 16'hffff};
      shiftNext = ctrlWr ? avlReq.writedata[`PBR_CTRL_SHIFT] : shiftReg;
      indNext   = ctrlWr ? avlReq.writedata[`PBR_CTRL_IND_EN] : indReg;
      pressNext = pushButtonN ? 32'h0 : pressReg + 32'h1;
      lowNext   = resetOutOe ? lowReg + 32'h1 : 32'h0;
      chgLvl    = indReg && chargerState.charging && !chargerState.done
                  && !chargerState.disabled && !chargerState.hiZ;
      pgExp     = shiftReg ? !pushButtonN : (vinAboveBatSleep && !vinOverVoltage);
   end

   // Helper registers; the fault age saturates so an old pulse never aliases.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         upReg    <= 3'h0;
         ageReg   <= 16'hffff;
         faultQ   <= 1'b0;
         shiftReg <= 1'b0;
         indReg   <= 1'b1;
         pressReg <= 32'h0;
         lowReg   <= 32'h0;
      end else begin
         upReg    <= upNext;
         ageReg   <= ageNext;
         faultQ   <= faultIn;
         shiftReg <= shiftNext;
         indReg   <= indNext;
         pressReg <= pressNext;
         lowReg   <= lowNext;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   one_wait_a: assert property (up && (avlReq.read || avlReq.write) && avlWaitrequest
      |=> !avlWaitrequest) else $error("bus request not answered after one wait");
   idle_wait_a: assert property (up && !avlReq.read && !avlReq.write
      |=> avlWaitrequest) else $error("waitrequest low without a request");
   unmapped_a: assert property (up && avlReq.read && !avlWaitrequest
      && avlReq.address > `PBR_OFF_TERM |-> avlReaddata == 32'h0)
      else $error("unmapped read not zero");
   power_good_a: assert property (up && $past(up) |-> powerGoodOe == $past(pgExp))
      else $error("power good line wrong");
   charge_line_a: assert property (up && ageReg > PHI
      |-> statusAlertOe == $past(chgLvl)) else $error("status line wrong");
   fault_pulse_a: assert property (up && ageReg >= 3 && ageReg <= PLO
      |-> statusAlertOe == !$past(chgLvl)) else $error("fault pulse missing");
   reset_hold_a: assert property ($rose(resetOutOe) |-> pressReg >= HOLD)
      else $error("reset output before hold time");
   reset_len_a: assert property ($fell(resetOutOe)
      |-> lowReg >= REL - 2 && lowReg <= REL + 2) else $error("reset length wrong");
   ship_exit_a: assert property (up && $fell(pushButtonN) |-> ##[1:4] !shipMode)
      else $error("press left ship mode set");
   term_pct_a: assert property (up && termWr |-> ##2 (termPercent == prechargePercent
      && termPercent == 5'h05 + {1'b0, $past(avlReq.writedata[3:0], 2)}))
      else $error("termination percent wrong");
endmodule // pbr_status_out_monitor

bind pbr_status_out pbr_status_out_monitor #(.US_CYCLES(US_CYCLES), .MS_US(MS_US),
   .PULSE_US(PULSE_US), .RELEASE_MS(RELEASE_MS)) pbr_status_out_monitor_i (.clk(clk),
   .reset_n(reset_n), .avlReq(avlReq), .avlWaitrequest(avlWaitrequest),
   .avlReaddata(avlReaddata), .chargerState(chargerState), .faultIn(faultIn),
   .vinAboveBatSleep(vinAboveBatSleep), .vinOverVoltage(vinOverVoltage),
   .pushButtonN(pushButtonN), .statusAlertOe(statusAlertOe), .powerGoodOe(powerGoodOe),
   .resetOutOe(resetOutOe), .shipMode(shipMode), .termPercent(termPercent),
   .prechargePercent(prechargePercent));

// ==== dv/pbr_status_out_bench.sv ====
// Self-checking bench for the push-button status block.
`timescale 1ns/1ps
`include "pbr_consts.svh"
module pbr_status_out_bench;
   import pbr_pkg::*;
   localparam int USC = 2;
   localparam int MSU = 3;
   localparam int PUL = 4;
   localparam int REL = 3;
   localparam int MSC = USC * MSU;
   logic         clk, reset_n, avlWaitrequest, faultIn, vinAboveBatSleep, vinOverVoltage;
   logic         pushButtonN, statusAlertOe, powerGoodOe, resetOutOe, shipMode, irq, pressGo;
   logic         statusLine, powerGoodLine, resetLineN;
   logic [31:0]  avlReaddata, pressLen;
   logic [4:0]   termPercent, prechargePercent;
   logic [3:0]   tempFaultIn;
   pbr_avl_req_t avlReq;
   pbr_chg_t     chargerState;
   int           fails, compares;

   pbr_status_out #(.US_CYCLES(USC), .MS_US(MSU), .PULSE_US(PUL), .RELEASE_MS(REL))
   pbr_status_out_i (.clk(clk), .reset_n(reset_n), .avlReq(avlReq),
      .avlWaitrequest(avlWaitrequest), .avlReaddata(avlReaddata), .chargerState(chargerState),
      .faultIn(faultIn), .vinAboveBatSleep(vinAboveBatSleep), .vinOverVoltage(vinOverVoltage),
      .tempFaultIn(tempFaultIn), .pushButtonN(pushButtonN), .statusAlertOut(),
      .statusAlertOe(statusAlertOe), .powerGoodOut(), .powerGoodOe(powerGoodOe),
      .resetOutN(), .resetOutOe(resetOutOe), .shipMode(shipMode), .termPercent(termPercent),
      .prechargePercent(prechargePercent), .irq(irq));

   pbr_far_end pbr_far_end_i (.clk(clk), .statusAlertOe(statusAlertOe),
      .powerGoodOe(powerGoodOe), .resetOutOe(resetOutOe), .pressGo(pressGo),
      .pressLen(pressLen), .pushButtonN(pushButtonN), .statusLine(statusLine),
      .powerGoodLine(powerGoodLine), .resetLineN(resetLineN));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic check_bit(input string nm, input logic exp, input logic got);
      check(nm, {31'h0, exp}, {31'h0, got});
   endtask

   // One Avalon transfer; the request holds until waitrequest is seen low.
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      avlReq <= '{read: rd, write: !rd, address: a, byteenable: 4'hf, writedata: d};
      @(posedge clk);
      while (avlWaitrequest !== 1'b0) begin
         @(posedge clk);
      end
      q = avlReaddata;
      avlReq <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b0, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      xfer(1'b1, a, 32'h0, q);
      check(nm, exp, q);
   endtask

   task automatic press(input int n);
      pressLen <= 32'(n);
      pressGo  <= 1'b1;
      @(posedge clk);
      pressGo  <= 1'b0;
   endtask

   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // The long button hold dominates the run; this limit leaves room to spare.
   initial begin
      tick(40000);
      fails++;
      wrap_up();
   end

   // Main sequence: reset, then one scenario after another.
   initial begin
      int n;
      reset_n = 1'b0;
      avlReq = '0;
      chargerState = '0;
      {faultIn, vinAboveBatSleep, vinOverVoltage, pressGo} = 4'h0;
      tempFaultIn = 4'h0;
      pressLen = 32'h0;
      fails = 0;
      compares = 0;
      tick(8);
      reset_n <= 1'b1;
      tick(3);
      rd(`PBR_OFF_CTRL, 32'h1, "ctrl");
      rd(`PBR_OFF_WAKE, 32'h03e80064, "wake");
      rd(`PBR_OFF_TERM, 32'h500, "term");
      rd(5'h18, 32'h0, "unmapped");
      chargerState <= pbr_chg_t'(4'h8);
      tempFaultIn <= 4'ha;
      tick(3);
      check_bit("charging", 1'b0, statusLine);
      rd(`PBR_OFF_STATE, 32'ha3, "state");
      wr(`PBR_OFF_CTRL, 32'h0);
      tick(1);
      check_bit("ind off", 1'b1, statusLine);
      wr(`PBR_OFF_CTRL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         chargerState <= pbr_chg_t'(4'h8 | (4'h4 >> i));
         tick(3);
         check_bit("stopped", 1'b1, statusLine);
      end
      chargerState <= pbr_chg_t'(4'h0);
      rd(`PBR_OFF_STATE, 32'h2, "state idle");
      // A fault sends one pulse and latches a flag that a read clears.
      faultIn <= 1'b1;
      tick(4);
      check_bit("pulse", 1'b0, statusLine);
      tick(12);
      check_bit("pulse end", 1'b1, statusLine);
      faultIn <= 1'b0;
      rd(`PBR_OFF_STATUS, 32'h1, "fault flag");
      rd(`PBR_OFF_STATUS, 32'h0, "cleared");
      wr(`PBR_OFF_MASK, 32'h1);
      faultIn <= 1'b1;
      tick(16);
      check_bit("irq", 1'b1, irq);
      rd(`PBR_OFF_STATUS, 32'h1, "fault again");
      tick(2);
      check_bit("irq off", 1'b0, irq);
      for (int i = 0; i < 4; i++) begin
         {vinAboveBatSleep, vinOverVoltage} <= 2'(i);
         tick(3);
         check_bit("power good", i != 2, powerGoodLine);
      end
      wr(`PBR_OFF_CTRL, 32'h3);
      press(10);
      tick(2);
      check_bit("shift low", 1'b0, powerGoodLine);
      tick(12);
      check_bit("shift high", 1'b1, powerGoodLine);
      wr(`PBR_OFF_CTRL, 32'h1);
      wr(`PBR_OFF_WAKE, 32'h00040002);
      rd(`PBR_OFF_STATUS, 32'h0, "no wake yet");
      press(18);
      tick(25);
      rd(`PBR_OFF_STATUS, 32'h2, "first wake");
      press(40);
      tick(45);
      rd(`PBR_OFF_STATUS, 32'h6, "both wakes");
      wr(`PBR_OFF_CTRL, 32'h5);
      tick(1);
      check_bit("ship", 1'b1, shipMode);
      press(4);
      tick(8);
      check_bit("ship exit", 1'b0, shipMode);
      rd(`PBR_OFF_STATUS, 32'h10, "ship flag");
      wr(`PBR_OFF_TERM, 32'hf);
      tick(2);
      check("term pct", 32'h14, {27'h0, termPercent});
      check("pre pct", 32'h14, {27'h0, prechargePercent});
      rd(`PBR_OFF_TERM, 32'h140f, "term max");
      // Long hold with hold select 0: reset only after the hold time.
      press(31000);
      tick(4999 * MSC);
      check_bit("no reset yet", 1'b1, resetLineN);
      n = 0;
      while (resetLineN !== 1'b0 && n < 4 * MSC) begin
         tick(1);
         n++;
      end
      check_bit("reset out", 1'b0, resetLineN);
      n = 0;
      while (resetLineN === 1'b0 && n < 1000) begin
         tick(1);
         n++;
      end
      check_bit("release", 1'b1, n >= REL * MSC - 2 && n <= REL * MSC + 2);
      rd(`PBR_OFF_STATUS, 32'he, "reset flag");
      wrap_up();
   end
endmodule // pbr_status_out_bench
